// [pio_pkg.sv]
package pio_pkg;

	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] PIO_ADDR_CFG  = 8'h00;
	localparam logic [7:0] PIO_ADDR_CTRL = 8'h04;
	localparam logic [7:0] PIO_ADDR_STAT = 8'h08;
	localparam logic [7:0] PIO_ADDR_CAPS = 8'h0c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PIO_CFG_PAT_LSB   = 0;
	localparam int PIO_CFG_PAT_MSB   = 2;
	localparam int PIO_CFG_SRV_DIS   = 3;
	localparam int PIO_CFG_HLD_DIS   = 4;
	localparam int PIO_CTRL_APPLY    = 0;
	localparam int PIO_CTRL_CLR      = 1;
	localparam int PIO_STAT_SERVO    = 3;
	localparam int PIO_STAT_PERMIT   = 4;
	localparam int PIO_STAT_TEACH    = 5;
	localparam int PIO_STAT_REFUSED  = 6;
	localparam int PIO_STAT_BUSY     = 7;
	localparam int PIO_CAPS_PTS_MSB  = 9;
	localparam int PIO_CAPS_ZONE_LSB = 12;
	localparam int PIO_CAPS_ZONE_MSB = 13;
	localparam int PIO_CAPS_TEACH    = 16;
	localparam int PIO_CAPS_DIRECT   = 17;
	localparam int PIO_CAPS_CYL      = 18;

	// ----------------------------------------
	// pattern codes and reset values
	// ----------------------------------------
	localparam logic [2:0] PIO_PAT_STD   = 3'h0;
	localparam logic [2:0] PIO_PAT_TEACH = 3'h1;
	localparam logic [2:0] PIO_PAT_256   = 3'h2;
	localparam logic [2:0] PIO_PAT_512   = 3'h3;
	localparam logic [2:0] PIO_PAT_DIR7  = 3'h4;
	localparam logic [2:0] PIO_PAT_CYL3  = 3'h5;
	localparam logic [2:0] PIO_PAT_RESET = PIO_PAT_STD;
	localparam logic       PIO_SRV_DIS_RESET = 1'b0;
	localparam logic       PIO_HLD_DIS_RESET = 1'b0;

	// ----------------------------------------
	// point counts and output masks
	// ----------------------------------------
	localparam logic [9:0] PIO_PTS_64  = 10'h040;
	localparam logic [9:0] PIO_PTS_256 = 10'h100;
	localparam logic [9:0] PIO_PTS_512 = 10'h200;
	localparam logic [9:0] PIO_PTS_7   = 10'h007;
	localparam logic [9:0] PIO_PTS_3   = 10'h003;
	localparam logic [6:0] PIO_MASK_7  = 7'h7f;
	localparam logic [6:0] PIO_MASK_3  = 7'h07;
	localparam logic [1:0] PIO_ZONES_2 = 2'h2;
	localparam logic [1:0] PIO_ZONES_1 = 2'h1;
	localparam logic [1:0] PIO_ZONES_0 = 2'h0;

	localparam logic [1:0] PIO_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

	typedef enum logic {PIO_BOOT, PIO_RUN} pio_state_t;

	// point index check, shared by moves and teaching stores
	function automatic logic pio_in_range(input logic [8:0] idx, input logic [9:0] cnt);
		return {1'b0, idx} < cnt;
	endfunction

endpackage

// [pio_pattern_decode.sv]
`timescale 1ns/100ps
`default_nettype none

module pio_pattern_decode
	import pio_pkg::*;
(
	// selected pattern
	input  wire logic [2:0] pat,
	// capabilities
	output logic      [9:0] pts,
	output logic      [1:0] zones,
	output logic            teach,
	output logic            direct,
	output logic            cyl,
	output logic      [6:0] dmask
);

	always_comb begin
		pts    = PIO_PTS_64;
		zones  = PIO_ZONES_0;
		teach  = 1'b0;
		direct = 1'b0;
		cyl    = 1'b0;
		dmask  = 7'h00;
		case (pat)
			PIO_PAT_STD: begin
				zones = PIO_ZONES_2; // see RULE_02
			end
			PIO_PAT_TEACH: begin
				zones = PIO_ZONES_1; // see RULE_04
				teach = 1'b1;
			end
			PIO_PAT_256: begin
				pts   = PIO_PTS_256; // see RULE_07
				zones = PIO_ZONES_1;
			end
			PIO_PAT_512: begin
				pts = PIO_PTS_512; // see RULE_08
			end
			PIO_PAT_DIR7: begin
				pts    = PIO_PTS_7; // see RULE_09
				direct = 1'b1;
				dmask  = PIO_MASK_7;
			end
			PIO_PAT_CYL3: begin
				pts    = PIO_PTS_3; // see RULE_10
				direct = 1'b1;
				cyl    = 1'b1;
				dmask  = PIO_MASK_3;
			end
			default: begin
				pts = 10'h000;
			end
		endcase
	end

endmodule
`default_nettype wire

// [pio_config.sv]
// What this block does
// RULE_01 - pattern 0..5 selected, default standard 0
// RULE_02 - standard: 64 points, two zone outputs
// RULE_03 - zone one parameter bounded, two table bounded
// RULE_04 - teaching: 64 points, one table zone
// RULE_05 - teaching mode jogs, stores position to entry
// RULE_06 - teaching pattern jogs in positioning too
// RULE_07 - pattern 2: 256 points, one table zone
// RULE_08 - pattern 3: 512 points, no zone
// RULE_09 - pattern 4: seven direct inputs and completes
// RULE_10 - pattern 5: three points, completes act as switches
// RULE_11 - servo-on disable parameter, default enabled
// RULE_12 - enabled servo-on input drives servo level
// RULE_13 - pause input active low, fail safe
// RULE_14 - plc holds pause asserted unless pausing
// RULE_15 - pause disable parameter, default enabled
// RULE_16 - disabled input ignored, treated as non-blocking
// RULE_17 - pattern latched, never changed during motion
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module pio_config
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// plc parallel inputs
	input  wire logic        servo_on_request,
	input  wire logic        pause_hold_n,
	input  wire logic        teach_mode_sel,
	input  wire logic        jog_fwd_req,
	input  wire logic        jog_rev_req,
	input  wire logic        store_req,
	input  wire logic        start_req,
	input  wire logic [8:0]  point_sel,
	input  wire logic [6:0]  direct_cmd,
	// motion core status
	input  wire logic        motion_busy,
	input  wire logic        move_done,
	input  wire logic [15:0] cur_position,
	input  wire logic [1:0]  zone_hit,
	input  wire logic [2:0]  at_point,
	// motion core commands
	output logic             servo_enable,
	output logic             motion_permit,
	output logic             move_start,
	output logic      [8:0]  move_point,
	output logic             jog_fwd,
	output logic             jog_rev,
	output logic             table_we,
	output logic      [8:0]  table_addr,
	output logic      [15:0] table_wdata,
	// plc parallel outputs
	output logic      [1:0]  zone_out,
	output logic      [6:0]  pos_complete,
	output logic             teach_active
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		pio_state_t  st;
		logic        aw_have;
		logic [7:0]  awaddr;
		logic        w_have;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [2:0]  cfg_pat;
		logic        srv_dis;
		logic        hld_dis;
		logic [2:0]  pat;
		logic        refused;
		logic        start_prev;
		logic        store_prev;
		logic [6:0]  dir_prev;
		logic        done_seen;
		logic [8:0]  last_point;
		logic        servo_enable;
		logic        motion_permit;
		logic        move_start;
		logic [8:0]  move_point;
		logic        jog_fwd;
		logic        jog_rev;
		logic        table_we;
		logic [8:0]  table_addr;
		logic [15:0] table_wdata;
		logic [1:0]  zone_out;
		logic [6:0]  pos_complete;
		logic        teach_active;
	} pio_regs_t;

	pio_regs_t s_q;
	pio_regs_t s_d;

	logic [9:0] cap_pts;
	logic [1:0] cap_zones;
	logic       cap_teach;
	logic       cap_direct;
	logic       cap_cyl;
	logic [6:0] cap_dmask;

	// ----------------------------------------
	// active pattern capabilities
	// ----------------------------------------
	pio_pattern_decode pio_pattern_decode_inst (
		.pat    (s_q.pat),
		.pts    (cap_pts),
		.zones  (cap_zones),
		.teach  (cap_teach),
		.direct (cap_direct),
		.cyl    (cap_cyl),
		.dmask  (cap_dmask)
	);

	function automatic logic [8:0] first_bit(input logic [6:0] v);
		logic [8:0] r;
		r = 9'h000;
		for (int i = 6; i >= 0; i--) begin
			if (v[i]) begin
				r = 9'(i);
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	logic       srv_ok;
	logic       stop_ok;
	logic       go_ok;
	logic       teach;
	logic [6:0] dir_v;
	logic [6:0] dir_rise;

	always_comb begin
		s_d = s_q;
		// disabled inputs read as non-blocking
		srv_ok   = s_q.srv_dis | servo_on_request; // see RULE_11, see RULE_16
		stop_ok  = s_q.hld_dis | pause_hold_n; // see RULE_15, see RULE_16
		go_ok    = srv_ok && stop_ok && !motion_busy; // see RULE_13
		teach    = cap_teach && teach_mode_sel;
		dir_v    = direct_cmd & cap_dmask;
		dir_rise = dir_v & ~s_q.dir_prev;
		s_d.move_start = 1'b0;
		s_d.table_we   = 1'b0;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.wdata  = s_axi_wdata;
			s_d.wstrb  = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = PIO_RESP_OKAY;
			case (s_q.awaddr)
				PIO_ADDR_CFG: begin
					if (s_q.wstrb[0]) begin
						s_d.cfg_pat = s_q.wdata[PIO_CFG_PAT_MSB:PIO_CFG_PAT_LSB];
						s_d.srv_dis = s_q.wdata[PIO_CFG_SRV_DIS];
						s_d.hld_dis = s_q.wdata[PIO_CFG_HLD_DIS];
					end
				end
				PIO_ADDR_CTRL: begin
					if (s_q.wstrb[0]) begin
						// clear first so a refusal in the same write wins
						if (s_q.wdata[PIO_CTRL_CLR]) begin
							s_d.refused = 1'b0;
						end
						if (s_q.wdata[PIO_CTRL_APPLY]) begin
							// remap only while idle, never mid move
							if (motion_busy || s_q.cfg_pat > PIO_PAT_CYL3) begin
								s_d.refused = 1'b1; // see RULE_17, see RULE_01
							end else begin
								s_d.pat = s_q.cfg_pat; // see RULE_17
							end
						end
					end
				end
				PIO_ADDR_STAT, PIO_ADDR_CAPS: begin
				end
				default: begin
					s_d.bresp = PIO_RESP_SLVERR;
				end
			endcase
		end
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;

		// read channel, answered on the cycle after the address
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = PIO_RESP_OKAY;
			s_d.rdata  = 32'h0000_0000;
			case (s_axi_araddr)
				PIO_ADDR_CFG: begin
					s_d.rdata[PIO_CFG_PAT_MSB:PIO_CFG_PAT_LSB] = s_q.cfg_pat;
					s_d.rdata[PIO_CFG_SRV_DIS] = s_q.srv_dis;
					s_d.rdata[PIO_CFG_HLD_DIS] = s_q.hld_dis;
				end
				PIO_ADDR_CTRL: begin
				end
				PIO_ADDR_STAT: begin
					s_d.rdata[PIO_CFG_PAT_MSB:PIO_CFG_PAT_LSB] = s_q.pat;
					s_d.rdata[PIO_STAT_SERVO]   = s_q.servo_enable;
					s_d.rdata[PIO_STAT_PERMIT]  = s_q.motion_permit;
					s_d.rdata[PIO_STAT_TEACH]   = s_q.teach_active;
					s_d.rdata[PIO_STAT_REFUSED] = s_q.refused;
					s_d.rdata[PIO_STAT_BUSY]    = motion_busy;
				end
				PIO_ADDR_CAPS: begin
					s_d.rdata[PIO_CAPS_PTS_MSB:0] = cap_pts;
					s_d.rdata[PIO_CAPS_ZONE_MSB:PIO_CAPS_ZONE_LSB] = cap_zones;
					s_d.rdata[PIO_CAPS_TEACH]  = cap_teach;
					s_d.rdata[PIO_CAPS_DIRECT] = cap_direct;
					s_d.rdata[PIO_CAPS_CYL]    = cap_cyl;
				end
				default: begin
					s_d.rresp = PIO_RESP_SLVERR;
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;

		// parallel io
		case (s_q.st)
			PIO_BOOT: begin
				// one quiet cycle while the reset pattern settles
				s_d.st = PIO_RUN;
			end
			PIO_RUN: begin
				s_d.servo_enable  = srv_ok; // see RULE_12
				s_d.motion_permit = stop_ok; // see RULE_13, see RULE_14
				s_d.teach_active  = teach;
				s_d.start_prev    = start_req;
				s_d.store_prev    = store_req;
				s_d.dir_prev      = dir_v;
				// jog in either mode of the teaching pattern
				s_d.jog_fwd = cap_teach && srv_ok && stop_ok
					&& jog_fwd_req && !jog_rev_req; // see RULE_05, see RULE_06
				s_d.jog_rev = cap_teach && srv_ok && stop_ok
					&& jog_rev_req && !jog_fwd_req; // see RULE_06
				if (cap_direct) begin
					// lowest newly pressed point wins
					if (go_ok && |dir_rise) begin
						s_d.move_start = 1'b1; // see RULE_09
						s_d.move_point = first_bit(dir_rise);
					end
				end else if (go_ok && !teach && start_req && !s_q.start_prev
						&& pio_in_range(point_sel, cap_pts)) begin
					s_d.move_start = 1'b1; // see RULE_02, see RULE_07, see RULE_08
					s_d.move_point = point_sel;
				end
				// out-of-range store silently dropped
				if (teach && store_req && !s_q.store_prev
						&& pio_in_range(point_sel, cap_pts)) begin
					s_d.table_we    = 1'b1; // see RULE_05
					s_d.table_addr  = point_sel;
					s_d.table_wdata = cur_position;
				end
				if (s_d.move_start) begin
					s_d.done_seen  = 1'b0;
					s_d.last_point = s_d.move_point;
				end
				if (move_done) begin
					s_d.done_seen = 1'b1;
				end
				if (cap_cyl) begin
					// level follows position, like a cylinder switch
					s_d.pos_complete = {4'h0, at_point}; // see RULE_10
				end else if (cap_direct) begin
					s_d.pos_complete = s_q.done_seen
						? 7'(7'h01 << s_q.last_point[2:0]) : 7'h00; // see RULE_09
				end else begin
					s_d.pos_complete = {6'h00, s_q.done_seen};
				end
				case (cap_zones)
					PIO_ZONES_2: s_d.zone_out = zone_hit; // see RULE_03
					PIO_ZONES_1: s_d.zone_out = {1'b0, zone_hit[1]}; // see RULE_04
					default:     s_d.zone_out = 2'h0; // see RULE_08
				endcase
			end
			default: begin
				s_d.st = PIO_BOOT;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q         <= '0;
			s_q.st      <= PIO_BOOT;
			s_q.cfg_pat <= PIO_PAT_RESET; // see RULE_01
			s_q.pat     <= PIO_PAT_RESET;
			s_q.srv_dis <= PIO_SRV_DIS_RESET; // see RULE_11
			s_q.hld_dis <= PIO_HLD_DIS_RESET; // see RULE_15
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rvalid  = s_q.rvalid;
	assign servo_enable  = s_q.servo_enable;
	assign motion_permit = s_q.motion_permit;
	assign move_start    = s_q.move_start;
	assign move_point    = s_q.move_point;
	assign jog_fwd       = s_q.jog_fwd;
	assign jog_rev       = s_q.jog_rev;
	assign table_we      = s_q.table_we;
	assign table_addr    = s_q.table_addr;
	assign table_wdata   = s_q.table_wdata;
	assign zone_out      = s_q.zone_out;
	assign pos_complete  = s_q.pos_complete;
	assign teach_active  = s_q.teach_active;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_pattern_range: // see RULE_01
	assert property (s_q.pat <= PIO_PAT_CYL3)
		else $error("active pattern out of range");
	chk_servo_follow: // see RULE_12
	assert property (s_q.st == PIO_RUN |=>
		servo_enable == ($past(s_q.srv_dis) | $past(servo_on_request)))
		else $error("servo enable does not follow input");
	chk_pause_follow: // see RULE_15
	assert property (s_q.st == PIO_RUN |=>
		motion_permit == ($past(s_q.hld_dis) | $past(pause_hold_n)))
		else $error("motion permit does not follow pause");
	chk_pause_blocks: // see RULE_13
	assert property (!motion_permit |-> !move_start && !jog_fwd && !jog_rev)
		else $error("motion issued while paused");
	chk_pattern_hold: // see RULE_17
	assert property (motion_busy |=> $stable(s_q.pat))
		else $error("pattern changed during motion");
	chk_zone_none: // see RULE_08
	assert property (s_q.pat == PIO_PAT_512 && s_q.st == PIO_RUN |=> zone_out == 2'h0)
		else $error("zone output in 512 point pattern");
	chk_jog_teach: // see RULE_06
	assert property ((jog_fwd || jog_rev) |-> $past(s_q.pat) == PIO_PAT_TEACH)
		else $error("jog outside teaching pattern");
	chk_store_pos: // see RULE_05
	assert property (table_we |-> table_wdata == $past(cur_position)
		&& $past(teach_mode_sel) && $past(s_q.pat) == PIO_PAT_TEACH)
		else $error("store without teaching or wrong data");
	chk_point_limit: // see RULE_09
	assert property (move_start |-> {1'b0, move_point} < $past(cap_pts))
		else $error("move point beyond pattern limit");
	chk_cyl_switch: // see RULE_10
	assert property (s_q.pat == PIO_PAT_CYL3 && s_q.st == PIO_RUN
		|=> pos_complete == {4'h0, $past(at_point)})
		else $error("cylinder switch output wrong");

	cov_direct_move: cover property (move_start && s_q.pat == PIO_PAT_DIR7);
	cov_teach_store: cover property (table_we);
	cov_apply_refused: cover property ($rose(s_q.refused));

endmodule
`default_nettype wire

// [pio_motion_model.sv]
`timescale 1ns/100ps
`default_nettype none

module pio_motion_model
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// commands from the block
	input  wire logic        move_start,
	input  wire logic [8:0]  move_point,
	input  wire logic        jog_fwd,
	input  wire logic        jog_rev,
	input  wire logic        table_we,
	input  wire logic [8:0]  table_addr,
	input  wire logic [15:0] table_wdata,
	// status back to the block
	output logic             motion_busy,
	output logic             move_done,
	output logic      [15:0] cur_position,
	output logic      [1:0]  zone_hit,
	output logic      [2:0]  at_point
);
	// ----------------------------------------
	// axis model
	// ----------------------------------------
	logic [4:0]  cnt_q;
	logic [8:0]  tgt_q;
	logic [15:0] tbl_q [512];

	// zones and switches follow low position bits, enough to toggle them
	assign zone_hit = cur_position[1:0];
	assign at_point = cur_position[2:0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			motion_busy  <= 1'b0;
			move_done    <= 1'b0;
			cur_position <= 16'h0003;
			cnt_q        <= 5'h00;
			tgt_q        <= 9'h000;
		end else begin
			move_done <= 1'b0;
			if (table_we) begin
				tbl_q[table_addr] <= table_wdata;
			end
			// a long move, so that the block can be tried while busy
			if (move_start) begin
				motion_busy <= 1'b1;
				cnt_q       <= 5'h18;
				tgt_q       <= move_point;
			end else if (motion_busy) begin
				cnt_q <= cnt_q - 5'h01;
				if (cnt_q == 5'h01) begin
					motion_busy  <= 1'b0;
					move_done    <= 1'b1;
					cur_position <= {7'h00, tgt_q};
				end
			end else if (jog_fwd) begin
				cur_position <= cur_position + 16'h0001;
			end else if (jog_rev) begin
				cur_position <= cur_position - 16'h0001;
			end
		end
	end
endmodule

`default_nettype wire

// [positioner_io_pattern_config_bench.sv]
`timescale 1ns/100ps
`default_nettype none

module positioner_io_pattern_config_bench
	import pio_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, servo_on_request, pause_hold_n, teach_mode_sel, jog_fwd_req;
	logic        jog_rev_req, store_req, start_req, motion_busy, move_done, servo_enable;
	logic        motion_permit, move_start, jog_fwd, jog_rev, table_we, teach_active;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, zone_hit, zone_out;
	logic [8:0]  point_sel, move_point, table_addr, st_pt, wr_addr;
	logic [6:0]  direct_cmd, pos_complete;
	logic [15:0] cur_position, table_wdata, wr_data;
	logic [2:0]  at_point;
	int          error_cnt = 0, n_compared = 0, n_st = 0, n_wr = 0;

	localparam logic [9:0] PTS_E [6] = '{10'h040, 10'h040, 10'h100, 10'h200, 10'h007, 10'h003};
	localparam logic [1:0] ZN_E [6] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
	// zone outputs expected while both zone inputs are hit
	localparam logic [1:0] ZO_E [6] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};

	pio_config pio_config_inst (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .servo_on_request, .pause_hold_n,
		.teach_mode_sel, .jog_fwd_req, .jog_rev_req, .store_req, .start_req, .point_sel,
		.direct_cmd, .motion_busy, .move_done, .cur_position, .zone_hit, .at_point,
		.servo_enable, .motion_permit, .move_start, .move_point, .jog_fwd, .jog_rev,
		.table_we, .table_addr, .table_wdata, .zone_out, .pos_complete, .teach_active);

	pio_motion_model pio_motion_model_inst (.clk, .arst_n, .move_start, .move_point,
		.jog_fwd, .jog_rev, .table_we, .table_addr, .table_wdata, .motion_busy,
		.move_done, .cur_position, .zone_hit, .at_point);

	// ----------------------------------------
	// clock, monitors, shared tasks
	// ----------------------------------------
	always #50 clk = ~clk;

	always @(posedge clk) begin
		if (move_start === 1'b1) begin
			n_st  <= n_st + 1;
			st_pt <= move_point;
		end
		if (table_we === 1'b1) begin
			n_wr    <= n_wr + 1;
			wr_addr <= table_addr;
			wr_data <= table_wdata;
		end
	end

	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s: saw %h, want %h", $time, what, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && t < 40);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk(t < 40, 1'b1, "write answer");
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int t;
		t = 0;
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(posedge clk);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && t < 40);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(t < 40, 1'b1, "read answer");
	endtask

	task automatic set_cfg(input logic [4:0] v, input logic app);
		logic [1:0] r;
		axi_wr(PIO_ADDR_CFG, {27'h0, v}, r);
		// clear with every apply, so the flag shows this apply only
		if (app) axi_wr(PIO_ADDR_CTRL, 32'h3, r);
	endtask

	// fresh rising start; the edge is lost when refused
	task automatic try_start(input logic [8:0] pt, input int exp);
		int n0;
		n0 = n_st;
		@(posedge clk);
		start_req <= 1'b0;
		point_sel <= pt;
		@(posedge clk);
		start_req <= 1'b1;
		tick(3);
		chk(n_st - n0, exp, "start count");
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(PIO_ADDR_CFG, d, r);
		chk(d, 32'h0, "cfg reset");
		axi_rd(PIO_ADDR_STAT, d, r);
		chk(d[7:0], 8'h10, "stat reset");
		axi_rd(8'h10, d, r);
		chk(d, 32'h0, "unmapped data");
		chk(r, PIO_RESP_SLVERR, "unmapped read");
		axi_wr(8'h14, 32'h5, r);
		chk(r, PIO_RESP_SLVERR, "unmapped write");
	endtask

	task automatic t_patterns();
		logic [31:0] d, e;
		logic [1:0]  r;
		for (int p = 0; p < 6; p++) begin
			set_cfg(p[4:0], 1'b1);
			axi_rd(PIO_ADDR_CAPS, d, r);
			// both fixed-point patterns start moves from direct inputs
			e = {13'h0, p == 5, p >= 4, p == 1, 2'h0, ZN_E[p], 2'h0, PTS_E[p]};
			chk(d, e, "caps");
			tick(2);
			chk(zone_out, ZO_E[p], "zone outputs");
		end
		chk(pos_complete[2:0], 3'h3, "switch outputs");
		set_cfg(5'h06, 1'b1);
		axi_rd(PIO_ADDR_STAT, d, r);
		chk(d[6:0], 7'h55, "bad pattern refused");
	endtask

	task automatic t_gating();
		for (int i = 0; i < 16; i++) begin
			set_cfg({i[3:2], 3'h0}, 1'b0);
			@(posedge clk);
			servo_on_request <= i[1];
			pause_hold_n     <= i[0];
			tick(2);
			chk(servo_enable, i[2] | i[1], "servo");
			chk(motion_permit, i[3] | i[0], "permit");
		end
		set_cfg(5'h00, 1'b1);
	endtask

	task automatic t_move();
		logic [31:0] d;
		logic [1:0]  r;
		try_start(9'd5, 1);
		chk(st_pt, 9'd5, "move point");
		set_cfg(5'h02, 1'b1);
		axi_rd(PIO_ADDR_STAT, d, r);
		chk(d[7:0], 8'hd8, "pattern kept in motion");
		tick(30);
		try_start(9'd64, 0);
		try_start(9'd63, 1);
		tick(30);
		@(posedge clk);
		pause_hold_n <= 1'b0;
		try_start(9'd6, 0);
		set_cfg(5'h10, 1'b0);
		try_start(9'd6, 1);
		tick(30);
		set_cfg(5'h00, 1'b0);
		@(posedge clk);
		pause_hold_n <= 1'b1;
	endtask

	task automatic t_teach();
		int          n0;
		logic [15:0] p;
		set_cfg(5'h01, 1'b1);
		@(posedge clk);
		teach_mode_sel <= 1'b1;
		jog_fwd_req    <= 1'b1;
		tick(2);
		chk({teach_active, jog_fwd}, 2'h3, "teach jog");
		@(posedge clk);
		jog_fwd_req <= 1'b0;
		try_start(9'd9, 0);
		n0 = n_wr;
		p  = cur_position;
		@(posedge clk);
		store_req <= 1'b1;
		tick(3);
		chk(n_wr - n0, 1, "store");
		chk({wr_addr, wr_data}, {9'd9, p}, "store entry");
		@(posedge clk);
		store_req      <= 1'b0;
		teach_mode_sel <= 1'b0;
		jog_rev_req    <= 1'b1;
		tick(2);
		chk({teach_active, jog_rev}, 2'h1, "jog in positioning");
		set_cfg(5'h00, 1'b1);
		tick(2);
		chk(jog_rev, 1'b0, "no jog in standard");
		@(posedge clk);
		jog_rev_req <= 1'b0;
	endtask

	task automatic t_direct();
		set_cfg(5'h04, 1'b1);
		@(posedge clk);
		direct_cmd <= 7'h40;
		tick(30);
		chk({st_pt, pos_complete}, {9'd6, 7'h40}, "direct seven");
		@(posedge clk);
		direct_cmd <= 7'h00;
		@(posedge clk);
		direct_cmd <= 7'h0a;
		tick(30);
		chk({st_pt, pos_complete}, {9'd1, 7'h02}, "lowest direct");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		clk    = 1'b0;
		arst_n = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, servo_on_request, store_req} = '0;
		{teach_mode_sel, jog_fwd_req, jog_rev_req, start_req, point_sel, direct_cmd} = '0;
		s_axi_wstrb  = 4'hf;
		pause_hold_n = 1'b1;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		tick(2);
		t_reset();
		t_patterns();
		t_gating();
		t_move();
		t_teach();
		t_direct();
		close_out();
	end

	initial begin
		#2000000;
		error_cnt++;
		close_out();
	end
endmodule

`default_nettype wire
